/* File: inc/hcp_regs.vh */
`ifndef HCP_REGS_VH
`define HCP_REGS_VH

// port offsets within the two-word window (address line a0)
`define HCP_DATA_OFFSET 1'b0
`define HCP_CMD_OFFSET 1'b1

// command register fields
`define HCP_CMD_WIDTH 16
`define HCP_CMD_RESET 16'h0000
`define HCP_CMD_SWRST_BIT 15
`define HCP_CMD_FRAME_ZERO_BIT 2
`define HCP_CMD_DEST_MSB 1
`define HCP_CMD_DEST_LSB 0

// destination_select codes
`define HCP_DEST_TX_BUFFER 2'b00
`define HCP_DEST_LATCH_ONE 2'b01
`define HCP_DEST_LATCH_TWO 2'b10
`define HCP_DEST_LATCH_THREE 2'b11

// status register fields
`define HCP_STAT_FRAME_ZERO_BIT 11
`define HCP_STAT_RESET 16'h0000

// data words sit in the low bits of the bus
`define HCP_DATA_WIDTH 12
`define HCP_BUS_WIDTH 16

// serial clock rates selected by the clock-rate switch, in hz
`define HCP_FAST_CLOCK_HZ 432000
`define HCP_SLOW_CLOCK_HZ 2400

`endif

/* File: rtl/hcp_latch.v */
`timescale 1ns/1ps
`default_nettype none
`include "hcp_regs.vh"

// debug latch: cleared only by the hardware reset, never by the software reset
module hcp_latch (
	input wire i_core_clk,
	input wire i_reset_n,
	input wire i_load,
	input wire [`HCP_DATA_WIDTH-1:0] i_data,
	output reg [`HCP_DATA_WIDTH-1:0] o_data
);

	always @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_data <= {`HCP_DATA_WIDTH{1'b0}}; // (R6)
		end else if (i_load) begin
			o_data <= i_data; // (R21)
		end
	end

endmodule // hcp_latch

`default_nettype wire

/* File: rtl/hcp_port.v */
// Operation
// (R1) serial clock is 432 kHz when clock-rate switch is 0, else 2.4 kHz
// (R2) line-format switch 0 selects RS232-level user data
// (R3) base-address switches must match host address lines A1..A3
// (R4) respond only to the two addresses base and base plus A0
// (R5) host asserts bus reset as hardware reset, usually at power-up
// (R6) hardware reset clears everything, debug latches included
// (R7) software reset clears everything except the debug latches
// (R8) command bit 15 is an active-high software reset held while set
// (R9) host writes 0 to bit 15 to release software reset
// (R10) destination 00 buffer, 01 latch one, 10 latch two
// (R11) host selects destination before the data write
// (R12) host keeps destination at zero for normal operation
// (R13) source or sink role follows only from addresses accessed
// (R14) frame-zero output follows a command bit written by host
// (R15) received frame-zero level is readable as a status bit
// (R16) destination 11 routes data writes to debug latch three
// (R17) frame-zero output comes from command bit 2, zero after reset
// (R18) received frame-zero level sits on status bit 11
// (R19) data words occupy the lower 12 of 16 data lines
// (R20) base plus one: write is command, read is status
// (R21) debug latch holds its value until rewritten or hardware reset
`timescale 1ns/1ps
`default_nettype none
`include "hcp_regs.vh"

module hcp_port (
	input wire i_core_clk,
	input wire i_reset_n,
	input wire [3:0] i_addr,
	input wire i_io_strobe,
	input wire i_write,
	input wire [`HCP_BUS_WIDTH-1:0] i_wdata,
	input wire i_clock_rate_switch,
	input wire i_line_format_switch,
	input wire i_base_addr_switch_msb,
	input wire i_base_addr_switch_mid,
	input wire i_base_addr_switch_lsb,
	input wire i_frame_zero_pulse,
	input wire [`HCP_DATA_WIDTH-1:0] i_rx_word,
	output reg [`HCP_BUS_WIDTH-1:0] o_rdata,
	output reg o_rdata_valid,
	output reg o_frame_zero_pulse,
	output reg o_soft_reset_n,
	output reg o_slow_clock_sel,
	output reg o_rs232_sel,
	output reg [`HCP_DATA_WIDTH-1:0] o_tx_word,
	output reg o_tx_load,
	output reg o_rx_read,
	output reg [`HCP_DATA_WIDTH-1:0] o_latch_one,
	output reg [`HCP_DATA_WIDTH-1:0] o_latch_two,
	output reg [`HCP_DATA_WIDTH-1:0] o_latch_three
);

	reg [`HCP_CMD_WIDTH-1:0] command_register;
	reg [2:0] latch_load;
	wire [`HCP_DATA_WIDTH-1:0] latch_q [0:2];
	wire board_sel;
	wire soft_rst;
	wire [1:0] dest;
	wire data_wr;
	wire data_rd;
	wire cmd_wr;
	wire stat_rd;
	wire [`HCP_BUS_WIDTH-1:0] status_word;
	reg [`HCP_BUS_WIDTH-1:0] next_rdata;
	reg [`HCP_DATA_WIDTH-1:0] next_tx_word;
	wire tx_wr;
	wire rx_rd;
	wire st_rd;

	// enable only when the three switches match A3..A1
	assign board_sel = i_io_strobe &&
		(i_addr[3:1] == {i_base_addr_switch_msb, i_base_addr_switch_mid,
		i_base_addr_switch_lsb}); // (R3)
	// role as source or sink comes purely from which address is touched
	assign data_wr = board_sel && i_write && (i_addr[0] == `HCP_DATA_OFFSET); // (R4) (R13)
	assign data_rd = board_sel && !i_write && (i_addr[0] == `HCP_DATA_OFFSET); // (R4) (R13)
	assign cmd_wr = board_sel && i_write && (i_addr[0] == `HCP_CMD_OFFSET); // (R20)
	assign stat_rd = board_sel && !i_write && (i_addr[0] == `HCP_CMD_OFFSET); // (R20)

	assign soft_rst = command_register[`HCP_CMD_SWRST_BIT]; // (R8)
	assign dest = command_register[`HCP_CMD_DEST_MSB:`HCP_CMD_DEST_LSB];

	assign status_word = {{(`HCP_BUS_WIDTH-`HCP_STAT_FRAME_ZERO_BIT-1){1'b0}},
		i_frame_zero_pulse, {`HCP_STAT_FRAME_ZERO_BIT{1'b0}}}; // (R15) (R18)

	// the command register must stay writable under software reset, or bit 15
	// could never be released again
	always @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			command_register <= `HCP_CMD_RESET; // (R6)
		end else if (cmd_wr) begin
			command_register <= i_wdata; // (R20)
		end
	end

	// data-write routing; during software reset nothing is routed
	always @* begin
		latch_load = 3'b000;
		if (data_wr && !soft_rst) begin
			case (dest)
				`HCP_DEST_LATCH_ONE: latch_load = 3'b001; // (R10)
				`HCP_DEST_LATCH_TWO: latch_load = 3'b010; // (R10)
				`HCP_DEST_LATCH_THREE: latch_load = 3'b100; // (R16)
				default: latch_load = 3'b000;
			endcase
		end
	end

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_latch
			// latches see only the hardware reset
			hcp_latch u_hcp_latch (
				.i_core_clk(i_core_clk),
				.i_reset_n(i_reset_n), // (R7)
				.i_load(latch_load[g]),
				.i_data(i_wdata[`HCP_DATA_WIDTH-1:0]), // (R19)
				.o_data(latch_q[g])
			);
		end
	endgenerate

	// strobes that still count; under software reset data and status go quiet
	assign tx_wr = data_wr && !soft_rst && (dest == `HCP_DEST_TX_BUFFER); // (R10)
	assign rx_rd = data_rd && !soft_rst; // (R7)
	assign st_rd = stat_rd && !soft_rst; // (R7)

	// next read answer; it stands until the next read or a software reset
	always @* begin
		next_rdata = o_rdata;
		if (soft_rst) begin
			next_rdata = `HCP_STAT_RESET; // (R7)
		end else if (rx_rd) begin
			// upper four lines read as zero
			next_rdata = {{(`HCP_BUS_WIDTH-`HCP_DATA_WIDTH){1'b0}}, i_rx_word}; // (R19)
		end else if (st_rd) begin
			next_rdata = status_word; // (R20)
		end
	end

	// next transmit word; the serial path outside takes it on the load strobe
	always @* begin
		next_tx_word = o_tx_word;
		if (soft_rst) begin
			next_tx_word = {`HCP_DATA_WIDTH{1'b0}}; // (R7)
		end else if (tx_wr) begin
			next_tx_word = i_wdata[`HCP_DATA_WIDTH-1:0]; // (R19)
		end
	end

	// switch copies; a soft reset leaves them alone, the switches cannot move
	always @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_slow_clock_sel <= 1'b1; // (R1)
			o_rs232_sel <= 1'b0;
		end else begin
			o_slow_clock_sel <= i_clock_rate_switch; // (R1)
			o_rs232_sel <= !i_line_format_switch; // (R2)
		end
	end

	// lags the command bit by one edge, together with the outputs it clears
	always @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_soft_reset_n <= 1'b1; // (R6)
		end else begin
			o_soft_reset_n <= !soft_rst; // (R8)
		end
	end

	// frame-zero output; pulse width is whatever the host spaces its two writes
	always @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_frame_zero_pulse <= 1'b0; // (R17)
		end else if (soft_rst) begin
			o_frame_zero_pulse <= 1'b0; // (R7)
		end else begin
			o_frame_zero_pulse <= command_register[`HCP_CMD_FRAME_ZERO_BIT]; // (R14) (R17)
		end
	end

	// transmit word and its one-cycle load strobe
	always @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_tx_word <= {`HCP_DATA_WIDTH{1'b0}}; // (R6)
			o_tx_load <= 1'b0;
		end else begin
			o_tx_word <= next_tx_word;
			o_tx_load <= tx_wr; // (R10)
		end
	end

	// read answer with its one-cycle strobes
	always @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= `HCP_STAT_RESET; // (R6)
			o_rdata_valid <= 1'b0;
			o_rx_read <= 1'b0;
		end else begin
			o_rdata <= next_rdata;
			o_rdata_valid <= rx_rd || st_rd; // (R20)
			o_rx_read <= rx_rd; // (R13)
		end
	end

	// latch contents go out through flip-flops, one edge behind the latches
	always @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_latch_one <= {`HCP_DATA_WIDTH{1'b0}}; // (R6)
			o_latch_two <= {`HCP_DATA_WIDTH{1'b0}};
			o_latch_three <= {`HCP_DATA_WIDTH{1'b0}};
		end else begin
			o_latch_one <= latch_q[0]; // (R7)
			o_latch_two <= latch_q[1];
			o_latch_three <= latch_q[2];
		end
	end

endmodule // hcp_port

`default_nettype wire

/* File: tb/hcp_port_props.sv */
`timescale 1ns/1ps
`default_nettype none
module hcp_port_props (
	input wire i_core_clk,
	input wire i_reset_n,
	input wire [3:0] i_addr,
	input wire i_io_strobe,
	input wire i_write,
	input wire [15:0] i_wdata,
	input wire i_clock_rate_switch,
	input wire i_line_format_switch,
	input wire i_base_addr_switch_msb,
	input wire i_base_addr_switch_mid,
	input wire i_base_addr_switch_lsb,
	input wire i_frame_zero_pulse,
	input wire [11:0] i_rx_word,
	input wire [15:0] o_rdata,
	input wire o_rdata_valid,
	input wire o_frame_zero_pulse,
	input wire o_soft_reset_n,
	input wire o_slow_clock_sel,
	input wire o_rs232_sel,
	input wire o_tx_load,
	input wire o_rx_read
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	wire [2:0] base = {i_base_addr_switch_msb, i_base_addr_switch_mid, i_base_addr_switch_lsb};
	wire hit = i_io_strobe && i_addr[3:1] == base;
	// command bit 15 as the block holds it; the registered flag lags by an edge
	logic swr_cmd;
	always @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			swr_cmd <= 1'b0;
		end else if (hit && i_write && i_addr[0]) begin
			swr_cmd <= i_wdata[15];
		end
	end
	wire rd = hit && !i_write && !swr_cmd;
	sequence s_cmd;
		hit && i_write && i_addr[0];
	endsequence
	property p_ign;
		i_io_strobe && !hit |=> !o_tx_load && !o_rdata_valid && !o_rx_read;
	endproperty
	property p_stat;
		rd && i_addr[0] |=> o_rdata_valid && o_rdata == {4'h0, $past(i_frame_zero_pulse), 11'h0};
	endproperty
	property p_rx;
		rd && !i_addr[0] |=> o_rx_read && o_rdata_valid && o_rdata == {4'h0, $past(i_rx_word)};
	endproperty
	property p_swq;
		!o_soft_reset_n |-> !o_tx_load && !o_rdata_valid && !o_rx_read && !o_frame_zero_pulse
			&& o_rdata == 16'h0000;
	endproperty
	property p_cmd;
		s_cmd |=> !o_rdata_valid && !o_tx_load;
	endproperty
	property p_clk;
		i_reset_n |=> o_slow_clock_sel == $past(i_clock_rate_switch);
	endproperty
	property p_fmt;
		i_reset_n |=> o_rs232_sel == !$past(i_line_format_switch);
	endproperty
	property p_swr;
		s_cmd ##0 i_wdata[15] |-> ##2 !o_soft_reset_n;
	endproperty
	property p_fz;
		s_cmd ##0 (!i_wdata[15] && o_soft_reset_n) |-> ##2 o_frame_zero_pulse == $past(i_wdata[2], 2);
	endproperty
	a_ign: assert property (p_ign) else $error("foreign address answered");
	a_stat: assert property (p_stat) else $error("status word wrong");
	a_rx: assert property (p_rx) else $error("data read wrong");
	a_cmd: assert property (p_cmd) else $error("command write misrouted");
	a_clk: assert property (p_clk) else $error("clock select wrong");
	a_fmt: assert property (p_fmt) else $error("line format wrong");
	a_swr: assert property (p_swr) else $error("soft reset missing");
	a_fz: assert property (p_fz) else $error("frame zero output wrong");
	a_swq: assert property (p_swq) else $error("outputs not quiet in soft reset");
endmodule // hcp_port_props
bind hcp_port hcp_port_props u_hcp_port_props (
	.i_core_clk(i_core_clk),
	.i_reset_n(i_reset_n),
	.i_addr(i_addr),
	.i_io_strobe(i_io_strobe),
	.i_write(i_write),
	.i_wdata(i_wdata),
	.i_clock_rate_switch(i_clock_rate_switch),
	.i_line_format_switch(i_line_format_switch),
	.i_base_addr_switch_msb(i_base_addr_switch_msb),
	.i_base_addr_switch_mid(i_base_addr_switch_mid),
	.i_base_addr_switch_lsb(i_base_addr_switch_lsb),
	.i_frame_zero_pulse(i_frame_zero_pulse),
	.i_rx_word(i_rx_word),
	.o_rdata(o_rdata),
	.o_rdata_valid(o_rdata_valid),
	.o_frame_zero_pulse(o_frame_zero_pulse),
	.o_soft_reset_n(o_soft_reset_n),
	.o_slow_clock_sel(o_slow_clock_sel),
	.o_rs232_sel(o_rs232_sel),
	.o_tx_load(o_tx_load),
	.o_rx_read(o_rx_read)
);
`default_nettype wire

/* File: tb/hcp_host.sv */
`timescale 1ns/1ps
`default_nettype none
module hcp_host (
	input wire logic i_clk,
	output logic [3:0] o_addr,
	output logic o_stb,
	output logic o_wr,
	output logic [15:0] o_wd
);
	initial {o_addr, o_stb, o_wr, o_wd} = 0;
	// one access, then idle two cycles so registered effects have landed
	task xfer(input logic [3:0] a, input logic w, input logic [15:0] d);
		@(negedge i_clk);
		{o_addr, o_stb, o_wr, o_wd} = {a, 1'b1, w, d};
		@(negedge i_clk);
		o_stb = 0;
		o_wd = ~d;
		repeat (2) @(negedge i_clk);
	endtask
endmodule // hcp_host
`default_nettype wire

/* File: tb/test_hcp_port.sv */
`timescale 1ns/1ps
`default_nettype none
module test_hcp_port;
	logic clk = 0, rst_n = 0, clk_sw = 1, fmt_sw = 0, fz = 0;
	wire [3:0] a;
	wire s, w, sr_n, fzo, ws, rs;
	wire [15:0] d, rd;
	wire [11:0] l1, l2, l3, tx;
	int num_errors = 0, compares = 0;
	always #5 clk = ~clk;
	hcp_host u_hcp_host (.i_clk(clk), .o_addr(a), .o_stb(s), .o_wr(w), .o_wd(d));
	hcp_port u_hcp_port (.i_core_clk(clk), .i_reset_n(rst_n), .i_addr(a), .i_io_strobe(s),
		.i_write(w), .i_wdata(d), .i_clock_rate_switch(clk_sw), .i_line_format_switch(fmt_sw),
		.i_base_addr_switch_msb(1'b1), .i_base_addr_switch_mid(1'b0),
		.i_base_addr_switch_lsb(1'b1), .i_frame_zero_pulse(fz), .i_rx_word(12'h5a5),
		.o_rdata(rd), .o_rdata_valid(), .o_frame_zero_pulse(fzo), .o_soft_reset_n(sr_n),
		.o_slow_clock_sel(ws), .o_rs232_sel(rs), .o_tx_word(tx), .o_tx_load(), .o_rx_read(),
		.o_latch_one(l1), .o_latch_two(l2), .o_latch_three(l3));
	task chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task summarize;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge clk);
		rst_n = 1;
		chk(sr_n, 1);
		chk(fzo, 0);
		for (int i = 1; i < 4; i++) begin
			u_hcp_host.xfer(4'hb, 1, 16'(i));
			u_hcp_host.xfer(4'ha, 1, 16'(16'hf000 | i * 16'h0111));
		end
		chk(l1, 12'h111);
		chk(l2, 12'h222);
		chk(l3, 12'h333);
		u_hcp_host.xfer(4'hb, 1, 0);
		u_hcp_host.xfer(4'ha, 1, 16'h0789);
		chk(tx, 12'h789);
		u_hcp_host.xfer(4'h2, 1, 16'h0abc);
		chk(tx, 12'h789);
		fz = 1;
		clk_sw = 0;
		u_hcp_host.xfer(4'hb, 0, 0);
		chk(rd, 16'h0800);
		chk(ws, 0);
		chk(rs, 1);
		u_hcp_host.xfer(4'ha, 0, 0);
		chk(rd, 16'h05a5);
		u_hcp_host.xfer(4'hb, 1, 4);
		chk(fzo, 1);
		u_hcp_host.xfer(4'hb, 1, 16'h8000);
		chk(sr_n, 0);
		chk(fzo, 0);
		chk(rd, 0);
		u_hcp_host.xfer(4'ha, 1, 16'h0123);
		chk(tx, 0);
		u_hcp_host.xfer(4'hb, 1, 0);
		chk(sr_n, 1);
		chk(l2, 12'h222);
		rst_n = 0;
		@(negedge clk);
		rst_n = 1;
		chk(l3, 0);
		summarize();
	end
	// whole run is well under 200 cycles
	initial begin
		#20000;
		num_errors++;
		summarize();
	end
endmodule // test_hcp_port
`default_nettype wire
